/* e1_spare_consts.svh */
`ifndef E1_SPARE_CONSTS_SVH
`define E1_SPARE_CONSTS_SVH
`define ADDR_W 8
`define OFF_TX_SI_ALIGN 8'h42
`define OFF_TX_SI_NONALIGN 8'h43
`define OFF_TX_REMOTE_ALARM 8'h44
`define OFF_TX_SA4 8'h45
`define OFF_TX_SA5 8'h46
`define OFF_TX_SA6 8'h47
`define OFF_TX_SA7 8'h48
`define OFF_TX_SA8 8'h49
`define OFF_TX_INSERT_CTRL 8'h4a
`define OFF_TX_NONALIGN_FRAME 8'h41
`define RST_FRAME_BITS 8'h00
`define RST_INSERT_CTRL 8'h00
`define RST_NONALIGN_FRAME 8'h40
`define CTRL_SA8 0
`define CTRL_SA7 1
`define CTRL_SA6 2
`define CTRL_SA5 3
`define CTRL_SA4 4
`define CTRL_RA 5
`define CTRL_SI_NONALIGN 6
`define CTRL_SI_ALIGN 7
`define NAF_SI 7
`define NAF_A 5
`define NAF_SA4 4
`define BITS_PER_FRAME 256
`define FRAMES_PER_MF 16
`define SA_FIRST_BIT 3
`define A_BIT 2
`define SI_BIT 0
`endif

/* e1_spare_pkg.sv */
package e1_spare_pkg;
  typedef enum logic [2:0] {
    SRC_PASS = 3'b000,
    SRC_PER_FRAME = 3'b001,
    SRC_NONALIGN_REG = 3'b010
  } bit_src_t;
  typedef logic [7:0] reg8_t;
endpackage : e1_spare_pkg

/* stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface stream_if;
  logic valid;
  logic ready;
  logic data;
  logic [3:0] frame;
  logic [7:0] slot;
  modport src (output valid, output data, output frame, output slot,
    input ready);
  modport snk (input valid, input data, input frame, input slot,
    output ready);
endinterface : stream_if
`default_nettype wire

/* e1_skid_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module e1_skid_buffer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Streams
  stream_if.snk up,
  stream_if.src dn
);
  // Two entries: full throughput and no combinational ready path
  logic [12:0] mem [2];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic ready_q;
  logic wrPtr_q;
  logic rdPtr_q;
  logic push;
  logic pop;

  // Ready from a flop, so the pin and the real take always agree
  assign up.ready = ready_q;
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  assign dn.valid = (cnt_q != 2'd0);
  assign {dn.data, dn.frame, dn.slot} = mem[rdPtr_q];
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 2'd0;
      ready_q <= 1'b0;
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != 2'd2);
      if (push) wrPtr_q <= ~wrPtr_q;
      if (pop) rdPtr_q <= ~rdPtr_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) mem[wrPtr_q] <= {up.data, up.frame, up.slot};
  end

  property p_no_overflow;
    @(posedge ref_clk) disable iff (!resetn) cnt_q == 2'd2 |-> !push;
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("Buffer pushed while full");
endmodule : e1_skid_buffer
`default_nettype wire

/* e1_tx_spare_bit_inserter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "e1_spare_consts.svh"
module e1_tx_spare_bit_inserter
  import e1_spare_pkg::*;
#(
  parameter int FRAME_BITS = `BITS_PER_FRAME
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Control port
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  output logic rdValid,
  // Serial transmit data in, one bit per beat
  input wire logic serial_tx_data_in,
  input wire logic txInValid,
  output logic txInReady,
  // Outgoing stream towards the formatter
  output logic txOut,
  output logic txOutValid,
  output logic [3:0] txOutFrame,
  output logic [7:0] txOutSlot,
  input wire logic txOutReady
);
  if (FRAME_BITS != `BITS_PER_FRAME) begin : g_bad_frame
    $error("Only 256-bit E1 frames supported");
  end

  reg8_t tx_si_align_frame_bits_q;
  reg8_t tx_si_nonalign_frame_bits_q;
  reg8_t tx_remote_alarm_frame_bits_q;
  reg8_t tx_sa4_frame_bits_q;
  reg8_t tx_sa5_frame_bits_q;
  reg8_t tx_sa6_frame_bits_q;
  reg8_t tx_sa7_frame_bits_q;
  reg8_t tx_sa8_frame_bits_q;
  reg8_t tx_overhead_insert_ctrl_q;
  reg8_t tx_nonalign_frame_reg_q;
  logic [3:0] frame_q;
  logic [7:0] slot_q;
  logic outBit;
  bit_src_t src;
  logic [2:0] frameIdx;
  logic beat;

  stream_if inS ();
  stream_if outS ();

  // Frame bit index: bit 7 holds frame 0/1, bit 0 frame 14/15
  function automatic logic pick(input reg8_t r, input logic [3:0] f);
    pick = r[3'd7 - f[3:1]];
  endfunction : pick

  // Control port writes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_si_align_frame_bits_q <= `RST_FRAME_BITS;
      tx_si_nonalign_frame_bits_q <= `RST_FRAME_BITS;
      tx_remote_alarm_frame_bits_q <= `RST_FRAME_BITS;
      tx_sa4_frame_bits_q <= `RST_FRAME_BITS;
      tx_sa5_frame_bits_q <= `RST_FRAME_BITS;
      tx_sa6_frame_bits_q <= `RST_FRAME_BITS;
      tx_sa7_frame_bits_q <= `RST_FRAME_BITS;
      tx_sa8_frame_bits_q <= `RST_FRAME_BITS;
      tx_overhead_insert_ctrl_q <= `RST_INSERT_CTRL;
      tx_nonalign_frame_reg_q <= `RST_NONALIGN_FRAME;
    end else if (wrEn) begin
      unique case (addr)
        `OFF_TX_SI_ALIGN: tx_si_align_frame_bits_q <= wrData;
        `OFF_TX_SI_NONALIGN: tx_si_nonalign_frame_bits_q <= wrData;
        `OFF_TX_REMOTE_ALARM: tx_remote_alarm_frame_bits_q <= wrData;
        `OFF_TX_SA4: tx_sa4_frame_bits_q <= wrData;
        `OFF_TX_SA5: tx_sa5_frame_bits_q <= wrData;
        `OFF_TX_SA6: tx_sa6_frame_bits_q <= wrData;
        `OFF_TX_SA7: tx_sa7_frame_bits_q <= wrData;
        `OFF_TX_SA8: tx_sa8_frame_bits_q <= wrData;
        `OFF_TX_INSERT_CTRL: tx_overhead_insert_ctrl_q <= wrData;
        `OFF_TX_NONALIGN_FRAME: tx_nonalign_frame_reg_q <= wrData;
        default: ;
      endcase
    end
  end

  // Control port reads, one cycle latency; unmapped reads as zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdData <= 8'h00;
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdEn;
      if (rdEn) begin
        unique case (addr)
          `OFF_TX_SI_ALIGN: rdData <= tx_si_align_frame_bits_q;
          `OFF_TX_SI_NONALIGN: rdData <= tx_si_nonalign_frame_bits_q;
          `OFF_TX_REMOTE_ALARM: rdData <= tx_remote_alarm_frame_bits_q;
          `OFF_TX_SA4: rdData <= tx_sa4_frame_bits_q;
          `OFF_TX_SA5: rdData <= tx_sa5_frame_bits_q;
          `OFF_TX_SA6: rdData <= tx_sa6_frame_bits_q;
          `OFF_TX_SA7: rdData <= tx_sa7_frame_bits_q;
          `OFF_TX_SA8: rdData <= tx_sa8_frame_bits_q;
          `OFF_TX_INSERT_CTRL: rdData <= tx_overhead_insert_ctrl_q;
          `OFF_TX_NONALIGN_FRAME: rdData <= tx_nonalign_frame_reg_q;
          default: rdData <= 8'h00;
        endcase
      end
    end
  end

  // Position in the multiframe advances per accepted input bit
  assign beat = txInValid && inS.ready;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      slot_q <= 8'h00;
      frame_q <= 4'h0;
    end else if (beat) begin
      slot_q <= slot_q + 8'h01;
      if (slot_q == 8'hff) frame_q <= frame_q + 4'h1;
    end
  end

  // Source selection for overhead positions of slot 0
  assign frameIdx = 3'd7 - frame_q[3:1];
  always_comb begin
    src = SRC_PASS;
    outBit = serial_tx_data_in;
    if (slot_q == 8'h00 && slot_q[2:0] == 3'd0) begin
      if (!frame_q[0]) begin
        if (tx_overhead_insert_ctrl_q[`CTRL_SI_ALIGN]) begin
          src = SRC_PER_FRAME;
          outBit = pick(tx_si_align_frame_bits_q, frame_q);
        end
      end else if (tx_overhead_insert_ctrl_q[`CTRL_SI_NONALIGN]) begin
        src = SRC_PER_FRAME;
        outBit = pick(tx_si_nonalign_frame_bits_q, frame_q);
      end else begin
        src = SRC_NONALIGN_REG;
        outBit = tx_nonalign_frame_reg_q[`NAF_SI];
      end
    end else if (slot_q == 8'(`A_BIT) && frame_q[0]) begin
      if (tx_overhead_insert_ctrl_q[`CTRL_RA]) begin
        src = SRC_PER_FRAME;
        outBit = pick(tx_remote_alarm_frame_bits_q, frame_q);
      end else begin
        src = SRC_NONALIGN_REG;
        outBit = tx_nonalign_frame_reg_q[`NAF_A];
      end
    end else if (slot_q >= 8'd3 && slot_q <= 8'd7 && frame_q[0]) begin
      src = SRC_NONALIGN_REG;
      outBit = tx_nonalign_frame_reg_q[`NAF_SA4 - (slot_q[2:0] - 3'd3)];
      unique case (slot_q[2:0])
        3'd3: if (tx_overhead_insert_ctrl_q[`CTRL_SA4]) begin
          src = SRC_PER_FRAME;
          outBit = pick(tx_sa4_frame_bits_q, frame_q);
        end
        3'd4: if (tx_overhead_insert_ctrl_q[`CTRL_SA5]) begin
          src = SRC_PER_FRAME;
          outBit = pick(tx_sa5_frame_bits_q, frame_q);
        end
        3'd5: if (tx_overhead_insert_ctrl_q[`CTRL_SA6]) begin
          src = SRC_PER_FRAME;
          outBit = pick(tx_sa6_frame_bits_q, frame_q);
        end
        3'd6: if (tx_overhead_insert_ctrl_q[`CTRL_SA7]) begin
          src = SRC_PER_FRAME;
          outBit = pick(tx_sa7_frame_bits_q, frame_q);
        end
        3'd7: if (tx_overhead_insert_ctrl_q[`CTRL_SA8]) begin
          src = SRC_PER_FRAME;
          outBit = pick(tx_sa8_frame_bits_q, frame_q);
        end
        default: ;
      endcase
    end
  end

  assign inS.valid = txInValid;
  assign inS.data = outBit;
  assign inS.frame = frame_q;
  assign inS.slot = slot_q;

  e1_skid_buffer u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .up(inS),
    .dn(outS)
  );

  // Output register stage; stalls back through the buffer
  assign outS.ready = !txOutValid || txOutReady;
  // Buffer ready is itself a flop
  assign txInReady = inS.ready;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txOut <= 1'b0;
      txOutValid <= 1'b0;
      txOutFrame <= 4'h0;
      txOutSlot <= 8'h00;
    end else begin
      if (outS.ready) begin
        txOutValid <= outS.valid;
        txOut <= outS.data;
        txOutFrame <= outS.frame;
        txOutSlot <= outS.slot;
      end
    end
  end

  property p_sa8_insert;
    @(posedge ref_clk) disable iff (!resetn)
      beat && frame_q[0] && slot_q == 8'd7
      && tx_overhead_insert_ctrl_q[`CTRL_SA8]
      |-> outBit == tx_sa8_frame_bits_q[frameIdx];
  endproperty
  a_sa8_insert: assert property (p_sa8_insert)
    else $error("Sa8 not inserted from register");

  property p_sa4_insert;
    @(posedge ref_clk) disable iff (!resetn)
      beat && frame_q[0] && slot_q == 8'd3
      && tx_overhead_insert_ctrl_q[`CTRL_SA4]
      |-> outBit == tx_sa4_frame_bits_q[frameIdx];
  endproperty
  a_sa4_insert: assert property (p_sa4_insert)
    else $error("Sa4 not inserted from register");

  property p_sa_off;
    @(posedge ref_clk) disable iff (!resetn)
      frame_q[0] && slot_q == 8'd5 && !tx_overhead_insert_ctrl_q[`CTRL_SA6]
      |-> outBit == tx_nonalign_frame_reg_q[2];
  endproperty
  a_sa_off: assert property (p_sa_off)
    else $error("Disabled Sa6 not from non-align register");

  property p_si_align;
    @(posedge ref_clk) disable iff (!resetn)
      !frame_q[0] && slot_q == 8'd0
      |-> outBit == (tx_overhead_insert_ctrl_q[`CTRL_SI_ALIGN] ?
          tx_si_align_frame_bits_q[frameIdx] : serial_tx_data_in);
  endproperty
  a_si_align: assert property (p_si_align)
    else $error("Align Si source wrong");

  property p_ra;
    @(posedge ref_clk) disable iff (!resetn)
      frame_q[0] && slot_q == 8'd2 && tx_overhead_insert_ctrl_q[`CTRL_RA]
      |-> outBit == tx_remote_alarm_frame_bits_q[frameIdx];
  endproperty
  a_ra: assert property (p_ra)
    else $error("Remote alarm not inserted");

  property p_payload_pass;
    @(posedge ref_clk) disable iff (!resetn)
      slot_q > 8'd7 |-> outBit == serial_tx_data_in && src == SRC_PASS;
  endproperty
  a_payload_pass: assert property (p_payload_pass)
    else $error("Payload bit altered");

  property p_frame_wrap;
    @(posedge ref_clk) disable iff (!resetn)
      beat && slot_q == 8'hff |=> frame_q == $past(frame_q) + 4'h1;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap)
    else $error("Frame counter did not advance");

  property p_ctrl_write;
    @(posedge ref_clk) disable iff (!resetn)
      wrEn && addr == `OFF_TX_INSERT_CTRL
      |=> tx_overhead_insert_ctrl_q == $past(wrData);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("Control write lost");

  property p_sa5_insert;
    @(posedge ref_clk) disable iff (!resetn)
      frame_q[0] && slot_q == 8'd4 && tx_overhead_insert_ctrl_q[`CTRL_SA5]
      |-> outBit == tx_sa5_frame_bits_q[frameIdx];
  endproperty
  a_sa5_insert: assert property (p_sa5_insert)
    else $error("Sa5 not inserted from register");

  property p_sa6_insert;
    @(posedge ref_clk) disable iff (!resetn)
      frame_q[0] && slot_q == 8'd5 && tx_overhead_insert_ctrl_q[`CTRL_SA6]
      |-> outBit == tx_sa6_frame_bits_q[frameIdx];
  endproperty
  a_sa6_insert: assert property (p_sa6_insert)
    else $error("Sa6 not inserted from register");

  property p_sa7_insert;
    @(posedge ref_clk) disable iff (!resetn)
      frame_q[0] && slot_q == 8'd6 && tx_overhead_insert_ctrl_q[`CTRL_SA7]
      |-> outBit == tx_sa7_frame_bits_q[frameIdx];
  endproperty
  a_sa7_insert: assert property (p_sa7_insert)
    else $error("Sa7 not inserted from register");

  property p_si_nonalign;
    @(posedge ref_clk) disable iff (!resetn)
      frame_q[0] && slot_q == 8'd0
      |-> outBit == (tx_overhead_insert_ctrl_q[`CTRL_SI_NONALIGN]
          ? tx_si_nonalign_frame_bits_q[frameIdx]
          : tx_nonalign_frame_reg_q[`NAF_SI]);
  endproperty
  a_si_nonalign: assert property (p_si_nonalign)
    else $error("Non-align Si source wrong");

  property p_ra_off;
    @(posedge ref_clk) disable iff (!resetn)
      frame_q[0] && slot_q == 8'd2 && !tx_overhead_insert_ctrl_q[`CTRL_RA]
      |-> outBit == tx_nonalign_frame_reg_q[`NAF_A];
  endproperty
  a_ra_off: assert property (p_ra_off)
    else $error("Disabled alarm bit not from non-align register");

  // Stalled beat must not move, or the line loses a bit
  sequence s_out_stalled;
    txOutValid && !txOutReady;
  endsequence

  property p_out_hold;
    @(posedge ref_clk) disable iff (!resetn)
      s_out_stalled |=> txOutValid && $stable(txOut)
      && $stable(txOutFrame) && $stable(txOutSlot);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("Output beat changed while stalled");
endmodule : e1_tx_spare_bit_inserter
`default_nettype wire

/* e1_line_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module e1_line_sink (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Pace: 0 always ready, 1 random stalls, 2 full stall
  input wire logic [1:0] mode,
  // Handshake towards the inserter
  output logic txOutReady
);
  // Random pacing keeps the skid buffer filling and draining
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txOutReady <= 1'b0;
    end else if (mode == 2'd0) begin
      txOutReady <= 1'b1;
    end else if (mode == 2'd1) begin
      txOutReady <= ($urandom % 4) != 0;
    end else begin
      txOutReady <= 1'b0;
    end
  end
endmodule : e1_line_sink
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import e1_spare_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic [7:0] rdData;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic rdValid;
  logic serial_tx_data_in = 1'b0;
  logic txInValid = 1'b0;
  logic txInReady;
  logic txOut;
  logic txOutValid;
  logic txOutReady;
  logic [3:0] txOutFrame;
  logic [7:0] txOutSlot;
  logic [1:0] sinkMode = 2'd0;
  logic sent [16];
  int nIn = 0;
  logic [15:0] e;
  reg8_t rv [16];
  int n_mismatch = 0;
  int n_checks = 0;
  int beats = 0;
  int quiet = 0;
  wire [15:0] got = {3'h0, txOut, txOutFrame, txOutSlot};

  e1_tx_spare_bit_inserter dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .rdValid(rdValid),
    .serial_tx_data_in(serial_tx_data_in), .txInValid(txInValid),
    .txInReady(txInReady), .txOut(txOut), .txOutValid(txOutValid),
    .txOutFrame(txOutFrame), .txOutSlot(txOutSlot),
    .txOutReady(txOutReady)
  );
  e1_line_sink sink_u (
    .ref_clk(ref_clk), .resetn(resetn), .mode(sinkMode),
    .txOutReady(txOutReady)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic stop_test;
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic wr(input reg8_t a, input reg8_t d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge ref_clk);
    wrEn <= 1'b0;
  endtask : wr

  task automatic rd(input reg8_t a, input reg8_t x);
    @(posedge ref_clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    #1;
    chk({7'h00, rdValid, rdData}, {8'h01, x});
  endtask : rd

  // Register copy rv mirrors what software wrote
  function automatic logic expBit(logic [3:0] f, logic [7:0] s, logic pb);
    int i;
    i = 7 - f[3:1];
    if (s == 0 && f[0]) return rv[10][6] ? rv[3][i] : rv[1][7];
    if (s == 0) return rv[10][7] ? rv[2][i] : pb;
    if (f[0] && s == 2) return rv[10][5] ? rv[4][i] : rv[1][5];
    if (f[0] && s >= 3 && s <= 7) return rv[10][7-s] ? rv[s+2][i] : rv[1][7-s];
    return pb;
  endfunction : expBit

  // Random line bits; a ring keeps those still in flight
  always @(posedge ref_clk) begin
    if (!resetn) begin
      beats = 0;
      nIn = 0;
    end else begin
      if (txInValid === 1'b1 && txInReady === 1'b1) begin
        sent[nIn[3:0]] = serial_tx_data_in;
        nIn++;
        serial_tx_data_in <= 1'($urandom);
      end
      if (txOutValid === 1'b1 && txOutReady === 1'b1) begin
        e = {3'h0, expBit(beats[11:8], beats[7:0], sent[beats[3:0]]),
          beats[11:0]};
        if (beats[7:0] == 0) chk(got, e);
        else chk(got, e);
        beats++;
        quiet = 0;
      end else begin
        quiet++;
      end
    end
  end

  initial begin
    reg8_t c;
    int b0;
    void'($urandom(91622));
    for (int i = 0; i < 16; i++) rv[i] = 8'h00;
    rv[1] = 8'h40;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int a = 1; a < 11; a++) rd(reg8_t'(8'h40 + a), rv[a]);
    // Unmapped place keeps nothing
    wr(8'h50, 8'hff);
    rd(8'h50, 8'h00);
    for (int p = 0; p < 11; p++) begin
      c = reg8_t'(p == 0 ? 8'h00 : p == 1 ? 8'hff :
        p < 10 ? 8'h01 << (p - 2) : $urandom);
      for (int a = 1; a < 10; a++) rv[a] = reg8_t'($urandom);
      rv[1][6] = 1'b1;
      rv[10] = c;
      for (int a = 1; a < 11; a++) wr(reg8_t'(8'h40 + a), rv[a]);
      for (int a = 1; a < 11; a++) rd(reg8_t'(8'h40 + a), rv[a]);
      @(posedge ref_clk);
      b0 = beats;
      txInValid <= 1'b1;
      sinkMode <= 2'd2;
      // Full stall: buffer must refuse, not drop
      repeat (10) @(posedge ref_clk);
      #1;
      chk({15'h0, txInReady}, 16'h0000);
      @(posedge ref_clk);
      sinkMode <= p[0] ? 2'd1 : 2'd0;
      for (int k = 0; k < 20000 && beats < b0 + 4096; k++) @(posedge ref_clk);
      if (beats < b0 + 4096) begin
        n_mismatch++;
        stop_test();
      end
      txInValid <= 1'b0;
      sinkMode <= 2'd0;
      for (int k = 0; k < 500 && quiet < 20; k++) @(posedge ref_clk);
      if (quiet < 20) begin
        n_mismatch++;
        stop_test();
      end
      chk(16'(beats), 16'(nIn));
    end
    // Second reset in mid-run restores defaults
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 16; i++) rv[i] = 8'h00;
    rv[1] = 8'h40;
    for (int a = 1; a < 11; a++) rd(reg8_t'(8'h40 + a), rv[a]);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
